//--- inc/prcfg_pkg.sv
package prcfg_pkg;
  // Register byte offsets
  localparam logic [18:0] PRCFG_OFS_CTRL = 19'h00000;
  localparam logic [18:0] PRCFG_OFS_ERR = 19'h00004;
  localparam logic [18:0] PRCFG_OFS_TALLY = 19'h00008;
  localparam logic [18:0] PRCFG_OFS_TIME = 19'h0000c;
  localparam logic [18:0] PRCFG_OFS_KEY = 19'h04000;
  localparam logic [18:0] PRCFG_OFS_MASK = 19'h08000;
  localparam logic [18:0] PRCFG_OFS_ROUTE = 19'h0c000;
  localparam logic [18:0] PRCFG_OFS_P2P = 19'h10000;
  // Last word of the point table; the address bus must reach it
  localparam logic [18:0] PRCFG_OFS_P2P_LAST = 19'h4fffc;
  // Table sizes
  localparam int PRCFG_MC_ENTRIES = 1024;
  localparam int PRCFG_P2P_ENTRIES = 65536;
  localparam int PRCFG_P2P_WIDTH = 3;
  // Control field positions
  localparam int PRCFG_CTL_ERRANT = 0;
  localparam int PRCFG_CTL_CPU_LO = 8;
  localparam int PRCFG_CTL_EMR_LO = 16;
  localparam int PRCFG_CTL_DROP_LO = 20;
  // Error field positions
  localparam int PRCFG_ERR_TX_LO = 0;
  localparam int PRCFG_ERR_CORE_LO = 6;
  localparam int PRCFG_ERR_PAR = 26;
  localparam int PRCFG_ERR_FRM = 27;
  localparam int PRCFG_ERR_TS = 28;
  localparam int PRCFG_ERR_IEN = 30;
  localparam int PRCFG_ERR_IACT = 31;
  localparam int PRCFG_NFLAGS = 29;
  // Reset values
  localparam logic [31:0] PRCFG_RST_WORD = 32'h00000000;
  localparam logic [4:0] PRCFG_RST_CPU = 5'h1f;
  localparam logic [3:0] PRCFG_RST_WAIT = 4'hf;
endpackage : prcfg_pkg

//--- rtl/prcfg_tables.sv
`timescale 1ns/1ps
// Write-only routing tables; contents feed the router lookup ports.
module prcfg_tables
  import prcfg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic mc_we_key,
  input wire logic mc_we_mask,
  input wire logic mc_we_route,
  input wire logic p2p_we,
  input wire logic [15:0] wr_index,
  input wire logic [31:0] wr_data,
  input wire logic [9:0] mc_rd_index,
  input wire logic [15:0] p2p_rd_index,
  output logic [31:0] mc_key,
  output logic [31:0] mc_mask,
  output logic [31:0] mc_route,
  output logic [2:0] p2p_route
);
  logic [31:0] key_mem [PRCFG_MC_ENTRIES];
  logic [31:0] mask_mem [PRCFG_MC_ENTRIES];
  logic [31:0] route_mem [PRCFG_MC_ENTRIES];
  logic [PRCFG_P2P_WIDTH-1:0] p2p_mem [PRCFG_P2P_ENTRIES];

  // Tables have no reset: software must load them before enabling routing
  always_ff @(posedge clk_sys) begin
    if (mc_we_key) begin
      key_mem[wr_index[9:0]] <= wr_data;
    end
    if (mc_we_mask) begin
      mask_mem[wr_index[9:0]] <= wr_data;
    end
    if (mc_we_route) begin
      route_mem[wr_index[9:0]] <= wr_data;
    end
    if (p2p_we) begin
      p2p_mem[wr_index] <= wr_data[PRCFG_P2P_WIDTH-1:0];
    end
    mc_key <= key_mem[mc_rd_index];
    mc_mask <= mask_mem[mc_rd_index];
    mc_route <= route_mem[mc_rd_index];
    p2p_route <= p2p_mem[p2p_rd_index];
  end
endmodule : prcfg_tables

//--- rtl/prcfg_regs.sv
`timescale 1ns/1ps
module prcfg_regs
  import prcfg_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST,
  // target port of the system network
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic [18:0] REQ_ADDR,
  input wire logic [31:0] REQ_WDATA,
  output logic RSP_VALID,
  output logic [31:0] RSP_RDATA,
  // Router events
  input wire logic PKT_PASSED,
  input wire logic [5:0] TX_DROP,
  input wire logic [5:0] TX_EMR_FAILED,
  input wire logic [19:0] CORE_DROP,
  input wire logic RX_PARITY_ERR,
  input wire logic RX_FRAMING_ERR,
  input wire logic RX_TIMESTAMP_ERR,
  // Router configuration outputs
  output logic ERRANT_TO_SUPERVISOR,
  output logic [4:0] SUPERVISOR_CPU_NUMBER,
  output logic [3:0] EMERGENCY_ROUTE_DELAY,
  output logic [3:0] DROP_DELAY,
  output logic ROUTER_IRQ,
  // Table lookup
  input wire logic [9:0] MC_RD_INDEX,
  input wire logic [15:0] P2P_RD_INDEX,
  output logic [31:0] MC_KEY,
  output logic [31:0] MC_MASK,
  output logic [31:0] MC_ROUTE,
  output logic [2:0] P2P_ROUTE
);
  typedef struct packed {
    logic errant;
    logic [4:0] cpu;
    logic [3:0] emr;
    logic [3:0] drop;
    logic [PRCFG_NFLAGS-1:0] flags;
    logic ien;
    logic irq;
    logic [31:0] tally;
    logic [31:0] time_word;
    logic rsp_valid;
    logic [31:0] rdata;
  } prcfg_state_t;

  prcfg_state_t st_r;
  prcfg_state_t st_nxt;
  logic wr_en;
  logic rd_en;
  logic we_key;
  logic we_mask;
  logic we_route;
  logic we_p2p;
  logic [PRCFG_NFLAGS-1:0] flag_set;
  logic [15:0] wr_index;

  // Multicast windows are 4 KB each; the gap behind them stays unmapped, so no aliasing
  function automatic logic in_window(input logic [18:0] addr, input logic [18:0] base);
    in_window = (addr[18:12] == base[18:12]);
  endfunction : in_window

  function automatic logic in_range(input logic [18:0] addr, input logic [18:0] lo, input logic [18:0] hi);
    in_range = (addr >= lo) && (addr <= hi);
  endfunction : in_range

  // Word index from a window base; 16 bits reach the last point entry
  function automatic logic [15:0] word_index(input logic [18:0] addr, input logic [18:0] base);
    logic [18:0] ofs;
    ofs = addr - base;
    word_index = ofs[17:2];
  endfunction : word_index

  // ==========================================================
  // Decode
  assign wr_en = REQ_VALID && REQ_WRITE;
  assign rd_en = REQ_VALID && !REQ_WRITE;
  assign we_key = wr_en && in_window(REQ_ADDR, PRCFG_OFS_KEY);
  assign we_mask = wr_en && in_window(REQ_ADDR, PRCFG_OFS_MASK);
  assign we_route = wr_en && in_window(REQ_ADDR, PRCFG_OFS_ROUTE);
  assign we_p2p = wr_en && in_range(REQ_ADDR, PRCFG_OFS_P2P, PRCFG_OFS_P2P_LAST);
  // Multicast tables use the low ten bits only
  assign wr_index = we_p2p ? word_index(REQ_ADDR, PRCFG_OFS_P2P) : {6'h00, REQ_ADDR[11:2]};

  // transmit drop only counts once emergency route failed
  assign flag_set = {RX_TIMESTAMP_ERR, RX_FRAMING_ERR, RX_PARITY_ERR, CORE_DROP, TX_DROP & TX_EMR_FAILED};

  // ==========================================================
  // Next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.rsp_valid = REQ_VALID;
    st_nxt.rdata = PRCFG_RST_WORD;
    if (wr_en) begin
      unique case (REQ_ADDR)
        PRCFG_OFS_CTRL: begin
          st_nxt.errant = REQ_WDATA[PRCFG_CTL_ERRANT];
          st_nxt.cpu = REQ_WDATA[PRCFG_CTL_CPU_LO +: 5];
          st_nxt.emr = REQ_WDATA[PRCFG_CTL_EMR_LO +: 4];
          st_nxt.drop = REQ_WDATA[PRCFG_CTL_DROP_LO +: 4];
        end
        PRCFG_OFS_ERR: begin
          st_nxt.flags = st_r.flags & REQ_WDATA[PRCFG_NFLAGS-1:0];
          st_nxt.ien = REQ_WDATA[PRCFG_ERR_IEN];
        end
        PRCFG_OFS_TIME: st_nxt.time_word = REQ_WDATA;
        default: ;
      endcase
    end
    st_nxt.flags = st_nxt.flags | flag_set;
    // count and wrap; write has priority
    if (wr_en && REQ_ADDR == PRCFG_OFS_TALLY) begin
      st_nxt.tally = REQ_WDATA;
    end else if (PKT_PASSED) begin
      st_nxt.tally = st_r.tally + 32'h00000001;
    end
    st_nxt.irq = st_nxt.ien && (|st_nxt.flags);
    if (rd_en) begin
      unique case (REQ_ADDR)
        // bit 31 active, bit 29 zero
        PRCFG_OFS_ERR: st_nxt.rdata = {st_r.irq, st_r.ien, 1'b0, st_r.flags};
        // read does not disturb the count
        PRCFG_OFS_TALLY: st_nxt.rdata = st_r.tally;
        PRCFG_OFS_TIME: st_nxt.rdata = st_r.time_word;
        default: st_nxt.rdata = PRCFG_RST_WORD;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      st_r <= '0;
      st_r.cpu <= PRCFG_RST_CPU;
      st_r.emr <= PRCFG_RST_WAIT;
      st_r.drop <= PRCFG_RST_WAIT;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign RSP_VALID = st_r.rsp_valid;
  assign RSP_RDATA = st_r.rdata;
  assign ERRANT_TO_SUPERVISOR = st_r.errant;
  assign SUPERVISOR_CPU_NUMBER = st_r.cpu;
  assign EMERGENCY_ROUTE_DELAY = st_r.emr;
  assign DROP_DELAY = st_r.drop;
  assign ROUTER_IRQ = st_r.irq;

  // ==========================================================
  // Tables
  prcfg_tables u_tables (
    .clk_sys(CLK_SYS),
    .mc_we_key(we_key),
    .mc_we_mask(we_mask),
    .mc_we_route(we_route),
    .p2p_we(we_p2p),
    .wr_index(wr_index),
    .wr_data(REQ_WDATA),
    .mc_rd_index(MC_RD_INDEX),
    .p2p_rd_index(P2P_RD_INDEX),
    .mc_key(MC_KEY),
    .mc_mask(MC_MASK),
    .mc_route(MC_ROUTE),
    .p2p_route(P2P_ROUTE)
  );

  // ==========================================================
  // Checks
  // flag holds unless cleared by write of zero
  sticky_hold_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    $past(st_r.flags[0]) && !($past(wr_en) && $past(REQ_ADDR) == PRCFG_OFS_ERR) |-> st_r.flags[0])
    else $error("sticky flag dropped");
  tx_set_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    TX_DROP[0] && TX_EMR_FAILED[0] |=> st_r.flags[0]) else $error("tx flag not set");
  parity_set_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    RX_PARITY_ERR |=> st_r.flags[PRCFG_ERR_PAR]) else $error("parity flag not set");
  tally_inc_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    PKT_PASSED && !wr_en |=> st_r.tally == $past(st_r.tally) + 32'h00000001) else $error("tally step");
  tally_load_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    wr_en && REQ_ADDR == PRCFG_OFS_TALLY |=> st_r.tally == $past(REQ_WDATA)) else $error("tally load");
  irq_level_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    ROUTER_IRQ == (st_r.ien && (|st_r.flags))) else $error("irq mismatch");
  cpu_write_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    wr_en && REQ_ADDR == PRCFG_OFS_CTRL |=> SUPERVISOR_CPU_NUMBER == $past(REQ_WDATA[12:8]))
    else $error("cpu number");
  err_read_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    rd_en && REQ_ADDR == PRCFG_OFS_ERR |=> RSP_RDATA[31] == $past(st_r.irq) && !RSP_RDATA[29])
    else $error("error read");

  core_set_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    CORE_DROP[0] |=> st_r.flags[PRCFG_ERR_CORE_LO])
    else $error("core flag not set");

  frame_set_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    RX_FRAMING_ERR |=> st_r.flags[PRCFG_ERR_FRM])
    else $error("framing flag not set");

  stamp_set_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    RX_TIMESTAMP_ERR |=> st_r.flags[PRCFG_ERR_TS])
    else $error("stamp flag not set");

  tx_guard_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    !st_r.flags[1] && !(TX_DROP[1] && TX_EMR_FAILED[1]) |=> !st_r.flags[1])
    else $error("tx flag set without emergency failure");

  flag_clear_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    wr_en && REQ_ADDR == PRCFG_OFS_ERR && !REQ_WDATA[PRCFG_ERR_PAR] && !RX_PARITY_ERR
    |=> !st_r.flags[PRCFG_ERR_PAR])
    else $error("flag not cleared");

  ien_write_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    wr_en && REQ_ADDR == PRCFG_OFS_ERR |=> st_r.ien == $past(REQ_WDATA[PRCFG_ERR_IEN]))
    else $error("interrupt enable");

  errant_write_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    wr_en && REQ_ADDR == PRCFG_OFS_CTRL |=> ERRANT_TO_SUPERVISOR == $past(REQ_WDATA[PRCFG_CTL_ERRANT]))
    else $error("errant bit");

  emr_write_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    wr_en && REQ_ADDR == PRCFG_OFS_CTRL |=> EMERGENCY_ROUTE_DELAY == $past(REQ_WDATA[PRCFG_CTL_EMR_LO +: 4]))
    else $error("emergency delay");

  drop_write_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    wr_en && REQ_ADDR == PRCFG_OFS_CTRL |=> DROP_DELAY == $past(REQ_WDATA[PRCFG_CTL_DROP_LO +: 4]))
    else $error("drop delay");

  rsp_pulse_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    !$past(RST) |-> RSP_VALID == $past(REQ_VALID))
    else $error("response pulse");

  tally_hold_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    !PKT_PASSED && !(wr_en && REQ_ADDR == PRCFG_OFS_TALLY) |=> $stable(st_r.tally))
    else $error("tally drift");

  tally_read_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    rd_en && REQ_ADDR == PRCFG_OFS_TALLY |=> RSP_RDATA == $past(st_r.tally))
    else $error("tally read");

  ctrl_read_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    rd_en && REQ_ADDR == PRCFG_OFS_CTRL |=> RSP_RDATA == PRCFG_RST_WORD)
    else $error("control read");

  time_write_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    wr_en && REQ_ADDR == PRCFG_OFS_TIME |=> st_r.time_word == $past(REQ_WDATA))
    else $error("time word");

  p2p_last_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    wr_en && REQ_ADDR == PRCFG_OFS_P2P_LAST |-> we_p2p && wr_index == 16'hffff)
    else $error("point index");

  key_gap_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    wr_en && REQ_ADDR[18:12] == PRCFG_OFS_KEY[18:12] + 7'h01 |-> !(we_key || we_mask || we_route || we_p2p))
    else $error("key gap write");
endmodule : prcfg_regs

//--- test/prcfg_host.sv
`timescale 1ns/1ps
// ==========================================
// Supervisor CPU side of the network target port
module prcfg_host (
  input wire logic clk_sys,
  output logic req_valid,
  output logic req_write,
  output logic [18:0] req_addr,
  output logic [31:0] req_wdata,
  input wire logic rsp_valid,
  input wire logic [31:0] rsp_rdata
);
  time rel_t;

  initial begin
    rel_t = 0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 19'h00000;
    req_wdata = 32'h00000000;
  end

  // one word per request
  // Caller enters just after an edge; idle address and data are inverted, not left stale
  task automatic xfer(input logic wr, input logic [18:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic ok);
    // Back to back calls let one edge pass so valid is never set twice in one step
    if ($time == rel_t) begin
      @(posedge clk_sys);
      #1;
    end
    req_valid = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    @(posedge clk_sys);
    #1;
    ok = rsp_valid;
    q = rsp_rdata;
    req_valid = 1'b0;
    req_addr = ~a;
    req_wdata = ~d;
    rel_t = $time;
  endtask : xfer
endmodule : prcfg_host

//--- test/packet_router_config_regs_bench.sv
`timescale 1ns/1ps
module packet_router_config_regs_bench;
  import prcfg_pkg::*;
  logic clk, rst, rv, rw, sv, pkt, par, frm, ts, errant;
  logic [18:0] ra;
  logic [31:0] wd, rd, key, msk, rte;
  logic [5:0] txd, txe;
  logic [19:0] core;
  logic [4:0] cpu;
  logic [3:0] emr, drp;
  logic irq;
  logic [9:0] mci;
  logic [15:0] ppi;
  logic [2:0] pp;
  logic [31:0] q;
  int n_mismatch = 0;
  int cmp_count = 0;

  prcfg_regs i_prcfg_regs (.CLK_SYS(clk), .RST(rst), .REQ_VALID(rv), .REQ_WRITE(rw), .REQ_ADDR(ra),
    .REQ_WDATA(wd), .RSP_VALID(sv), .RSP_RDATA(rd), .PKT_PASSED(pkt), .TX_DROP(txd), .TX_EMR_FAILED(txe),
    .CORE_DROP(core), .RX_PARITY_ERR(par), .RX_FRAMING_ERR(frm), .RX_TIMESTAMP_ERR(ts),
    .ERRANT_TO_SUPERVISOR(errant), .SUPERVISOR_CPU_NUMBER(cpu), .EMERGENCY_ROUTE_DELAY(emr),
    .DROP_DELAY(drp), .ROUTER_IRQ(irq), .MC_RD_INDEX(mci), .P2P_RD_INDEX(ppi), .MC_KEY(key),
    .MC_MASK(msk), .MC_ROUTE(rte), .P2P_ROUTE(pp));
  prcfg_host i_prcfg_host (.clk_sys(clk), .req_valid(rv), .req_write(rw), .req_addr(ra),
    .req_wdata(wd), .rsp_valid(sv), .rsp_rdata(rd));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ==========================================
  // Helpers
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic acc(input logic w, input logic [18:0] a, input logic [31:0] d);
    logic ok;
    i_prcfg_host.xfer(w, a, d, q, ok);
    chk("rsp_valid", 32'h00000001, {31'h0, ok});
  endtask : acc

  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick

  task automatic complete_run();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  // ==========================================
  // Scenarios
  task automatic t_ctrl();
    chk("cpu_rst", 32'h0000001f, {27'h0, cpu});
    acc(1'b1, PRCFG_OFS_CTRL, 32'hff5aea01);
    chk("errant", 32'h00000001, {31'h0, errant});
    chk("cpu", 32'h0000000a, {27'h0, cpu});
    chk("delays", 32'h0000005a, {24'h0, drp, emr});
    acc(1'b0, PRCFG_OFS_CTRL, 32'h0);
    chk("ctrl_rd", 32'h0, q);
  endtask : t_ctrl

  task automatic t_flags();
    txd = 6'h3f;
    txe = 6'h05;
    tick();
    txd = 6'h00;
    txe = 6'h3a;
    core = 20'h80001;
    {par, frm, ts} = 3'h7;
    tick();
    txe = 6'h00;
    core = 20'h0;
    {par, frm, ts} = 3'h0;
    chk("irq_off", 32'h0, {31'h0, irq});
    acc(1'b0, PRCFG_OFS_ERR, 32'h0);
    chk("flags", 32'h1e000045, q);
    acc(1'b1, PRCFG_OFS_ERR, 32'hffffffff);
    chk("irq_on", 32'h1, {31'h0, irq});
    acc(1'b0, PRCFG_OFS_ERR, 32'h0);
    chk("flags_kept", 32'h9e000045, q & 32'hbfffffff);
    acc(1'b1, PRCFG_OFS_ERR, 32'h40000000);
    chk("irq_clr", 32'h0, {31'h0, irq});
    acc(1'b0, PRCFG_OFS_ERR, 32'h0);
    chk("flags_clr", 32'h0, q & 32'hbfffffff);
    par = 1'b1;
    tick();
    par = 1'b0;
    chk("irq_par", 32'h1, {31'h0, irq});
  endtask : t_flags

  task automatic t_tally();
    acc(1'b1, PRCFG_OFS_TALLY, 32'hfffffffe);
    pkt = 1'b1;
    tick();
    tick();
    pkt = 1'b0;
    acc(1'b0, PRCFG_OFS_TALLY, 32'h0);
    chk("tally_wrap", 32'h0, q);
    acc(1'b0, PRCFG_OFS_TALLY, 32'h0);
    chk("tally_hold", 32'h0, q);
    pkt = 1'b1;
    acc(1'b1, PRCFG_OFS_TALLY, 32'h00000100);
    pkt = 1'b0;
    acc(1'b0, PRCFG_OFS_TALLY, 32'h0);
    chk("tally_load", 32'h00000100, q);
    acc(1'b1, PRCFG_OFS_TIME, 32'h5a5a1234);
    acc(1'b0, PRCFG_OFS_TIME, 32'h0);
    chk("time_word", 32'h5a5a1234, q);
  endtask : t_tally

  task automatic t_tables();
    acc(1'b1, PRCFG_OFS_KEY + 19'h00014, 32'h11223344);
    acc(1'b1, PRCFG_OFS_MASK + 19'h00014, 32'h55667788);
    acc(1'b1, PRCFG_OFS_ROUTE + 19'h00014, 32'h99aabbcc);
    acc(1'b1, PRCFG_OFS_P2P + 19'h0000c, 32'h00000006);
    acc(1'b1, PRCFG_OFS_P2P_LAST, 32'h00000005);
    acc(1'b1, PRCFG_OFS_KEY + 19'h01014, 32'hdeadbeef);
    acc(1'b0, PRCFG_OFS_KEY + 19'h00014, 32'h0);
    chk("key_rd", 32'h0, q);
    mci = 10'h005;
    ppi = 16'h0003;
    tick();
    chk("key", 32'h11223344, key);
    chk("mask", 32'h55667788, msk);
    chk("route", 32'h99aabbcc, rte);
    chk("p2p", 32'h6, {29'h0, pp});
    ppi = 16'hffff;
    tick();
    chk("p2p_last", 32'h5, {29'h0, pp});
  endtask : t_tables

  initial begin
    rst = 1'b1;
    {pkt, par, frm, ts} = 4'h0;
    txd = 6'h0;
    txe = 6'h0;
    core = 20'h0;
    mci = 10'h0;
    ppi = 16'h0;
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    t_ctrl();
    t_flags();
    t_tally();
    t_tables();
    complete_run();
  end

  initial begin
    #200000;
    n_mismatch++;
    complete_run();
  end
endmodule : packet_router_config_regs_bench
